//--- etc_defines.vh
`ifndef ETC_DEFINES_VH
`define ETC_DEFINES_VH
// Command byte field positions.
`define ETC_CMD_CONT_SEL 7
`define ETC_CMD_SUPPLY_SEL 6
`define ETC_CMD_TRIM_HI 5
`define ETC_CMD_TRIM_LO 3
`define ETC_CMD_CONT_CLR 2
`define ETC_CMD_SUPPLY_CLR 1
`define ETC_CMD_READ 0
// Transfer lengths in serial clocks.
`define ETC_CMD_BITS 8
`define ETC_DATA_BITS 32
// Reset values.
`define ETC_TRIM_RESET 3'h3
`define ETC_COUNT_RESET 32'h00000000
// Time base: 1 s at 25 MHz.
`define ETC_CLK_HZ 25000000
`define ETC_SECOND_CYCLES (`ETC_CLK_HZ)
`define ETC_FIFO_DEPTH 4
`endif

//--- etc_counter_port.v
`timescale 1ns/1ps
`default_nettype none
`include "etc_defines.vh"
// Summary of operation
// (R1) Command bits: selects, trim, clears, direction.
// (R2) Continuous select read shifts out 32 bits.
// (R3) Single select write loads 32 bits.
// (R4) Supply select read shifts out 32 bits.
// (R5) No select, clear bit zeroes continuous counter.
// (R6) No select, clear bit zeroes supply counter.
// (R7) Both selects write loads trim bits.
// (R8) Tick output only with supply and oscillator.
// (R9) Serial access blocked when supply invalid.
// (R10) Host holds enable high through transfers.
// (R11) Input bits sampled on rising serial clock.
// (R12) Data driven only while serial clock low.
// (R13) Write data jammed at 32nd clock.
// (R14) Enable low aborts and releases data line.
// (R15) Bits shifted least significant first.

// ****************************************
// Word FIFO
// ****************************************
module etc_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 4
)(
	input wire i_mclk,
	input wire i_reset,
	input wire i_flush,
	input wire i_in_valid,
	output wire o_in_ready,
	input wire [WIDTH-1:0] i_in_data,
	output wire o_out_valid,
	input wire i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);
	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [2:0] wr_reg;
	reg [2:0] rd_reg;
	reg [3:0] cnt_reg;
	wire push;
	wire pop;
	integer k;
	assign o_in_ready = (cnt_reg != DEPTH[3:0]);
	assign o_out_valid = (cnt_reg != 4'h0);
	assign o_out_data = mem_reg[rd_reg[1:0]];
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;
	// Pointers, count and storage.
	always @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			wr_reg <= 3'h0;
			rd_reg <= 3'h0;
			cnt_reg <= 4'h0;
			for (k = 0; k < DEPTH; k = k + 1)
				mem_reg[k] <= {WIDTH{1'b0}};
		end
		else if (i_flush)
		begin
			wr_reg <= 3'h0;
			rd_reg <= 3'h0;
			cnt_reg <= 4'h0;
		end
		else
		begin
			if (push)
			begin
				mem_reg[wr_reg[1:0]] <= i_in_data;
				wr_reg <= wr_reg + 3'h1;
			end
			if (pop)
				rd_reg <= rd_reg + 3'h1;
			if (push && !pop)
				cnt_reg <= cnt_reg + 4'h1;
			else if (pop && !push)
				cnt_reg <= cnt_reg - 4'h1;
		end
	end
endmodule

// ****************************************
// Serial port and counters
// ****************************************
module etc_counter_port (
	input wire i_mclk,
	input wire i_reset,
	input wire i_enable,
	input wire i_sclk,
	input wire i_dq_in,
	output reg o_dq_out,
	output reg o_dq_oe_n,
	input wire i_supply_valid,
	output reg o_tick_1hz_out
);
	// Synchronisers: three flops; enable, clock and supply changes count when second and third agree.
	reg [2:0] en_sync_reg;
	reg [2:0] clk_sync_reg;
	reg [2:0] dq_sync_reg;
	reg [2:0] sv_sync_reg;
	reg en_reg;
	reg clk_reg;
	reg sv_reg;
	reg [7:0] cmd_reg;
	reg [5:0] bit_reg;
	reg [31:0] shift_reg;
	reg [31:0] cont_count_reg;
	reg [31:0] supply_count_reg;
	reg [2:0] trim_reg;
	reg [24:0] sec_reg;
	reg [3:0] state_reg;
	wire clk_rise;
	wire clk_fall;
	wire tick;
	wire [7:0] cmd_next;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [31:0] fifo_out_data;
	reg fifo_push;
	reg [31:0] fifo_data;
	localparam S_IDLE = 4'b0001;
	localparam S_CMD = 4'b0010;
	localparam S_DATA = 4'b0100;
	localparam S_DONE = 4'b1000;
	// Second time base end points, cut to the 25-bit divider width where they are used.
	localparam [31:0] SEC_LAST = `ETC_SECOND_CYCLES - 1;
	localparam [31:0] SEC_HALF = `ETC_SECOND_CYCLES / 2;
	assign clk_rise = (clk_sync_reg[2] == clk_sync_reg[1]) && clk_sync_reg[1] && !clk_reg;
	assign clk_fall = (clk_sync_reg[2] == clk_sync_reg[1]) && !clk_sync_reg[1] && clk_reg;
	assign tick = (sec_reg == SEC_LAST[24:0]);
	assign cmd_next = {dq_sync_reg[2], cmd_reg[7:1]}; // (R15)

	// Write words queue here and are applied to a counter one per cycle.
	etc_fifo #(.WIDTH(32), .DEPTH(`ETC_FIFO_DEPTH)) u_fifo (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_flush(1'b0),
		.i_in_valid(fifo_push),
		.o_in_ready(fifo_in_ready),
		.i_in_data(fifo_data),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(1'b1),
		.o_out_data(fifo_out_data)
	);

	// Input synchronisers and filtered levels.
	always @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			en_sync_reg <= 3'h0;
			clk_sync_reg <= 3'h0;
			dq_sync_reg <= 3'h0;
			sv_sync_reg <= 3'h0;
			en_reg <= 1'b0;
			clk_reg <= 1'b0;
			sv_reg <= 1'b0;
		end
		else
		begin
			en_sync_reg <= {en_sync_reg[1:0], i_enable};
			clk_sync_reg <= {clk_sync_reg[1:0], i_sclk};
			dq_sync_reg <= {dq_sync_reg[1:0], i_dq_in};
			sv_sync_reg <= {sv_sync_reg[1:0], i_supply_valid};
			if (en_sync_reg[2] == en_sync_reg[1])
				en_reg <= en_sync_reg[1];
			if (clk_sync_reg[2] == clk_sync_reg[1])
				clk_reg <= clk_sync_reg[1];
			if (sv_sync_reg[2] == sv_sync_reg[1])
				sv_reg <= sv_sync_reg[1];
		end
	end

	// Second time base, counters and tick output; trim is set by the serial engine.
	always @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			sec_reg <= 25'h0000000;
			cont_count_reg <= `ETC_COUNT_RESET;
			supply_count_reg <= `ETC_COUNT_RESET;
			o_tick_1hz_out <= 1'b0;
		end
		else
		begin
			// A zero trim stops the oscillator.
			if (trim_reg == 3'h0)
				sec_reg <= sec_reg;
			else if (tick)
				sec_reg <= 25'h0000000;
			else
				sec_reg <= sec_reg + 25'h0000001;
			o_tick_1hz_out <= sv_reg && (trim_reg != 3'h0) && (sec_reg < SEC_HALF[24:0]); // (R8)
			if (state_reg == S_DONE && cmd_reg[7:6] == 2'b00 && cmd_reg[`ETC_CMD_CONT_CLR])
				cont_count_reg <= `ETC_COUNT_RESET; // (R5)
			else if (fifo_out_valid && cmd_reg[7:6] == 2'b10)
				cont_count_reg <= fifo_out_data; // (R3) (R13)
			else if (tick && trim_reg != 3'h0)
				cont_count_reg <= cont_count_reg + 32'h1;
			if (state_reg == S_DONE && cmd_reg[7:6] == 2'b00 && cmd_reg[`ETC_CMD_SUPPLY_CLR])
				supply_count_reg <= `ETC_COUNT_RESET; // (R6)
			else if (fifo_out_valid && cmd_reg[7:6] == 2'b01)
				supply_count_reg <= fifo_out_data; // (R3) (R13)
			else if (tick && sv_reg && trim_reg != 3'h0)
				supply_count_reg <= supply_count_reg + 32'h1;
		end
	end

	// Serial protocol engine.
	always @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			state_reg <= S_IDLE;
			cmd_reg <= 8'h00;
			bit_reg <= 6'h00;
			shift_reg <= 32'h0;
			trim_reg <= `ETC_TRIM_RESET;
			o_dq_out <= 1'b0;
			o_dq_oe_n <= 1'b1;
			fifo_push <= 1'b0;
			fifo_data <= 32'h0;
		end
		else
		begin
			fifo_push <= 1'b0;
			if (!en_reg || !sv_reg) // (R9) (R10) (R14)
			begin
				state_reg <= (state_reg == S_CMD || state_reg == S_DATA) ? S_DONE : S_IDLE;
				if (state_reg == S_DATA || state_reg == S_CMD)
					cmd_reg <= (state_reg == S_CMD) ? 8'h00 : cmd_reg;
				o_dq_oe_n <= 1'b1;
				bit_reg <= 6'h00;
			end
			else
			begin
				case (state_reg)
					S_IDLE:
					begin
						state_reg <= S_CMD;
						bit_reg <= 6'h00;
					end
					S_CMD:
						if (clk_rise) // (R11)
						begin
							cmd_reg <= cmd_next; // (R1)
							bit_reg <= bit_reg + 6'h01;
							if (bit_reg == `ETC_CMD_BITS - 1)
							begin
								bit_reg <= 6'h00;
								state_reg <= S_DATA;
								if (cmd_next[7:6] == 2'b11 && !cmd_next[`ETC_CMD_READ])
									trim_reg <= cmd_next[`ETC_CMD_TRIM_HI:`ETC_CMD_TRIM_LO]; // (R7)
								shift_reg <= cmd_next[7] ? cont_count_reg : supply_count_reg; // (R2) (R4)
							end
						end
					S_DATA:
					begin
						// Read: drive while clock low, release while high.
						if (cmd_reg[0] && cmd_reg[7] != cmd_reg[6] && bit_reg < `ETC_DATA_BITS)
						begin
							if (clk_fall)
							begin
								o_dq_out <= shift_reg[0]; // (R15)
								o_dq_oe_n <= 1'b0; // (R12)
							end
							else if (clk_rise)
							begin
								o_dq_oe_n <= 1'b1; // (R12)
								shift_reg <= {1'b0, shift_reg[31:1]}; // (R2) (R4)
								bit_reg <= bit_reg + 6'h01;
							end
						end
						else if (!cmd_reg[0] && cmd_reg[7] != cmd_reg[6] && bit_reg < `ETC_DATA_BITS && clk_rise)
						begin
							shift_reg <= {dq_sync_reg[2], shift_reg[31:1]}; // (R11) (R15)
							bit_reg <= bit_reg + 6'h01;
							if (bit_reg == `ETC_DATA_BITS - 1 && fifo_in_ready)
							begin
								fifo_data <= {dq_sync_reg[2], shift_reg[31:1]}; // (R13)
								fifo_push <= 1'b1;
							end
						end
						else
							o_dq_oe_n <= 1'b1;
					end
					S_DONE:
						state_reg <= S_IDLE;
					default:
						state_reg <= S_IDLE;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

//--- etc_port_props.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Checker
// ********
module etc_port_props (
	input wire i_mclk,
	input wire i_reset,
	input wire i_enable,
	input wire i_sclk,
	input wire i_dq_in,
	input wire o_dq_out,
	input wire o_dq_oe_n,
	input wire i_supply_valid,
	input wire o_tick_1hz_out
);
	// All checks sample on the system clock and sleep in reset.
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_reset);
	AST_SCLK_RELEASE: assert property ($rose(i_sclk) |-> ##[1:8] o_dq_oe_n)
		else $error("data line held after clock rise");
	AST_ABORT: assert property ($fell(i_enable) |-> ##[1:8] o_dq_oe_n)
		else $error("data line held after enable fall");
	AST_NO_SUPPLY: assert property (!i_supply_valid [*8] |-> o_dq_oe_n)
		else $error("data line driven without supply");
	AST_TICK_OFF: assert property (!i_supply_valid [*8] |-> !o_tick_1hz_out)
		else $error("tick present without supply");
	AST_BIT_STANDS: assert property (!o_dq_oe_n && $past(!o_dq_oe_n) |-> $stable(o_dq_out))
		else $error("read bit changed while driven");
	AST_DRIVE_CAUSE: assert property ($fell(o_dq_oe_n) |-> !$past(i_sclk, 4) && $past(i_enable, 4))
		else $error("drive began without low clock and enable");
	AST_TICK_CAUSE: assert property ($rose(o_tick_1hz_out) |-> $past(i_supply_valid, 2))
		else $error("tick rose without supply");
	AST_HIGH_LIMIT: assert property ((!o_dq_oe_n && i_sclk) [*7] |=> o_dq_oe_n)
		else $error("data line driven through clock high");
endmodule
// The checker rides on every instance of the port.
bind etc_counter_port etc_port_props u_props (.i_mclk(i_mclk), .i_reset(i_reset), .i_enable(i_enable),
	.i_sclk(i_sclk), .i_dq_in(i_dq_in), .o_dq_out(o_dq_out), .o_dq_oe_n(o_dq_oe_n),
	.i_supply_valid(i_supply_valid), .o_tick_1hz_out(o_tick_1hz_out));
`default_nettype wire

//--- etc_host.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Host model
// ********
module etc_host (
	input wire logic i_mclk,
	input wire logic i_dq_out,
	input wire logic i_dq_oe_n,
	output logic o_enable,
	output logic o_sclk,
	output wire logic o_dq
);
	logic drv = 0, val = 0, alt = 0;
	logic [39:0] rx;
	// Wire level: device when driving, else host, else a changing pattern.
	assign o_dq = !i_dq_oe_n ? i_dq_out : (drv ? val : alt);
	// The pattern flips every cycle so a floating line never looks stable.
	always @(negedge i_mclk)
		alt <= ~alt;
	initial
	begin
		o_enable = 0;
		o_sclk = 0;
	end
	// One framed transfer: command, nd data bits, then enable low while clock high.
	task xfer(input logic [7:0] cmd, input int nd, input logic [31:0] wd, output logic [31:0] rd);
		int i, k;
		rx = '1;
		@(negedge i_mclk);
		o_enable = 1;
		repeat (4) @(negedge i_mclk);
		for (i = 0; i < 8 + nd; i++)
		begin
			drv = !(i >= 8 && cmd[0]);
			val = (i < 8) ? cmd[i] : wd[i - 8];
			for (k = 0; k < 8; k++)
			begin
				@(negedge i_mclk);
				o_sclk = (k >= 3);
				if (!i_dq_oe_n)
					rx[i] = i_dq_out;
			end
		end
		@(negedge i_mclk);
		o_enable = 0;
		drv = 0;
		@(negedge i_mclk);
		o_sclk = 0;
		repeat (30) @(negedge i_mclk);
		rd = rx[39:8];
	endtask
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CMP(nm, e, s) begin checks++; if ((s) !== (e)) begin mismatches++; \
	$display("mismatch %s exp %h got %h", nm, e, s); end end
// ********
// Bench top
// ********
module testbench;
	logic i_mclk, i_reset, i_supply_valid, en, sclk, dq_out, dq_oe_n, tick;
	wire dq;
	int mismatches = 0, checks = 0;
	logic [31:0] rd;
	etc_counter_port u_dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_enable(en), .i_sclk(sclk), .i_dq_in(dq),
		.o_dq_out(dq_out), .o_dq_oe_n(dq_oe_n), .i_supply_valid(i_supply_valid), .o_tick_1hz_out(tick));
	etc_host u_host (.i_mclk(i_mclk), .i_dq_out(dq_out), .i_dq_oe_n(dq_oe_n), .o_enable(en), .o_sclk(sclk), .o_dq(dq));
	// Free-running 25 MHz system clock.
	initial
	begin
		i_mclk = 0;
		forever #20 i_mclk = ~i_mclk;
	end
	// Prints the counts and the verdict, then stops.
	task finish_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Continuous counter write and read, with an aborted read and a cut write between.
	task t_cont;
		u_host.xfer(8'h80, 32, 32'ha5c30f1e, rd);
		u_host.xfer(8'h81, 4, 32'h0, rd);
		u_host.xfer(8'h80, 16, 32'h5a5a5a5a, rd);
		u_host.xfer(8'h81, 32, 32'h0, rd);
		`CMP("cont", 32'ha5c30f1e, rd)
	endtask
	// Supply counter write and read leave the continuous counter alone.
	task t_supply;
		u_host.xfer(8'h40, 32, 32'h80000001, rd);
		u_host.xfer(8'h41, 32, 32'h0, rd);
		`CMP("supply", 32'h80000001, rd)
		u_host.xfer(8'h81, 32, 32'h0, rd);
		`CMP("cont kept", 32'ha5c30f1e, rd)
	endtask
	// Single clear, then both clears together.
	task t_clear;
		`CMP("tick", 1'b1, tick)
		u_host.xfer(8'h04, 0, 32'h0, rd);
		u_host.xfer(8'h81, 32, 32'h0, rd);
		`CMP("cont clr", 32'h0, rd)
		u_host.xfer(8'h41, 32, 32'h0, rd);
		`CMP("supply kept", 32'h80000001, rd)
		u_host.xfer(8'h06, 0, 32'h0, rd);
		u_host.xfer(8'h41, 32, 32'h0, rd);
		`CMP("supply clr", 32'h0, rd)
	endtask
	// With the supply gone the tick stops and reads are refused.
	task t_off;
		u_host.xfer(8'h80, 32, 32'h0000ffff, rd);
		@(negedge i_mclk);
		i_supply_valid = 0;
		repeat (12) @(negedge i_mclk);
		`CMP("tick off", 1'b0, tick)
		u_host.xfer(8'h81, 32, 32'h0, rd);
		`CMP("refused", 32'hffffffff, rd)
		u_host.xfer(8'h80, 32, 32'h12345678, rd);
		i_supply_valid = 1;
		repeat (12) @(negedge i_mclk);
	endtask
	// Trim write to zero stops the tick and leaves the continuous counter alone; the refused write left no mark.
	task t_trim;
		u_host.xfer(8'hc6, 0, 32'h0, rd);
		repeat (12) @(negedge i_mclk);
		`CMP("tick stop", 1'b0, tick)
		u_host.xfer(8'h81, 32, 32'h0, rd);
		`CMP("cont trim", 32'h0000ffff, rd)
	endtask
	// Main sequence: reset for three cycles, then each scenario.
	initial
	begin
		i_reset = 1;
		i_supply_valid = 1;
		repeat (3) @(posedge i_mclk);
		@(negedge i_mclk);
		i_reset = 0;
		repeat (12) @(negedge i_mclk);
		t_cont;
		t_supply;
		t_clear;
		t_off;
		t_trim;
		finish_test;
	end
	// Watchdog well beyond the expected run of about 5000 cycles.
	initial
	begin
		#2000000;
		mismatches++;
		finish_test;
	end
endmodule
`default_nettype wire
